// ==== src/usrx_pkg.sv ====
// Shared constants and types of the serial receive core
`default_nettype none
package usrx_pkg;
    // ==========================================
    // Operating modes
    localparam logic [1:0] MODE_ASYNC = 2'h0;
    localparam logic [1:0] MODE_SYNC = 2'h1;
    localparam logic [1:0] MODE_SPI = 2'h3;
    localparam logic [1:0] RXM_DOUBLE = 2'h1;
    localparam logic [1:0] RXM_RESYNC = 2'h3;
    // ==========================================
    // Character sizes, bit counts and frame width
    localparam logic [2:0] CHS_9L = 3'h6;
    localparam logic [2:0] CHS_9H = 3'h7;
    localparam logic [3:0] SPI_BITS = 4'h8;
    localparam logic [3:0] MAX_BITS = 4'h9;
    localparam int FRAME_W = 13;
    // ==========================================
    // Sampling: last sample index and first vote sample
    localparam logic [3:0] SMP_NORM = 4'hf;
    localparam logic [3:0] SMP_DBL = 4'h7;
    localparam logic [3:0] VOTE_NORM = 4'h7;
    localparam logic [3:0] VOTE_DBL = 4'h3;
    // ==========================================
    // Buffer entry and rx_high_byte layout
    localparam int RXBUF_DEPTH = 2;
    localparam int EN_PARITY_ERROR_FLAG = 9;
    localparam int EN_FRAME_ERROR_FLAG = 10;
    localparam int EN_OVF = 11;
    localparam int HB_RXC = 7;
    localparam int HB_OVF = 6;
    localparam int HB_FRAME_ERROR_FLAG = 2;
    localparam int HB_PARITY_ERROR_FLAG = 1;
    localparam int HB_D8 = 0;
    // ==========================================
    // Reset values
    localparam logic LINE_IDLE = 1'b1;
    localparam logic [2:0] VOTE_IDLE = 3'h7;
    typedef enum logic [2:0] {
        RX_IDLE,
        RX_START,
        RX_DATA,
        RX_PAR,
        RX_STOP
    } usrx_rx_st_t;
endpackage : usrx_pkg
`default_nettype wire

// ==== src/usrx_rxbuf.sv ====
// Two-frame receive buffer with per-frame status bits
`default_nettype none
module usrx_rxbuf #(
    parameter int DEPTH = usrx_pkg::RXBUF_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Fill side
    input wire logic flush,
    input wire logic push,
    input wire logic [8:0] push_data,
    input wire logic push_frame_error_flag,
    input wire logic push_parity_error_flag,
    input wire logic ovf_en,
    // Drain side
    input wire logic pop,
    output logic [7:0] low_byte,
    output logic [7:0] high_byte,
    output logic not_empty
);
    typedef struct packed {
        logic [1:0] cnt;
        logic [1:0][11:0] e;
        logic [7:0] lo;
        logic [7:0] hi;
        logic ne;
    } usrx_buf_st_t;
    usrx_buf_st_t s;
    usrx_buf_st_t n;

    generate
        if (DEPTH != 2)
        begin : g_depth_chk
            $error("Receive buffer holds exactly two frames");
        end
    endgenerate

    // ==========================================
    // Next state
    always_comb
    begin
        n = s;
        if (flush)
            n.cnt = 2'h0;
        else
        begin
            if (pop && s.cnt != 2'h0)
            begin
                n.e[0] = s.e[1];
                n.cnt = s.cnt - 2'h1;
            end
            // Push after pop so a same-cycle pair loses nothing
            if (push)
            begin
                if (n.cnt == 2'h2)
                    n.e[1] = {ovf_en, push_frame_error_flag, push_parity_error_flag, push_data};
                else
                begin
                    n.e[n.cnt[0]] = {1'b0, push_frame_error_flag, push_parity_error_flag, push_data};
                    n.cnt = n.cnt + 2'h1;
                end
            end
        end
        n.ne = (n.cnt != 2'h0);
        n.lo = n.ne ? n.e[0][7:0] : 8'h0;
        n.hi = 8'h0;
        n.hi[usrx_pkg::HB_RXC] = n.ne;
        n.hi[usrx_pkg::HB_OVF] = n.ne & n.e[0][usrx_pkg::EN_OVF];
        n.hi[usrx_pkg::HB_FRAME_ERROR_FLAG] = n.ne & n.e[0][usrx_pkg::EN_FRAME_ERROR_FLAG];
        n.hi[usrx_pkg::HB_PARITY_ERROR_FLAG] = n.ne & n.e[0][usrx_pkg::EN_PARITY_ERROR_FLAG];
        n.hi[usrx_pkg::HB_D8] = n.ne & n.e[0][8];
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            s <= '0;
        else
            s <= n;
    end

    assign low_byte = s.lo;
    assign high_byte = s.hi;
    assign not_empty = s.ne;

    // ==========================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_ovf_mark: assert property (
        push && !pop && !flush && s.cnt == 2'h2 && ovf_en
        |=> s.e[1][usrx_pkg::EN_OVF])
        else $error("Overflow not marked on overwritten frame");
    a_pop_order: assert property (
        pop && !push && !flush && s.cnt == 2'h2
        |=> s.cnt == 2'h1 && s.e[0] == $past(s.e[1]))
        else $error("Second frame did not move to head");
    c_buf_full: cover property (push && s.cnt == 2'h2);
endmodule : usrx_rxbuf
`default_nettype wire

// ==== src/usrx_core.sv ====
// Serial transceiver core: receive path, clocking and host SPI
`default_nettype none
module usrx_core (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Configuration
    input wire logic [1:0] comm_mode,
    input wire logic [1:0] rx_mode,
    input wire logic [2:0] character_size,
    input wire logic [1:0] parity_mode,
    input wire logic two_stop,
    input wire logic bit_order_select,
    input wire logic clock_phase_select,
    input wire logic pin_invert_enable,
    input wire logic transfer_clock_dir,
    input wire logic [15:0] baud_div,
    input wire logic tx_enable,
    input wire logic rx_enable,
    // Transmit data
    input wire logic tx_write,
    input wire logic [7:0] tx_low_byte,
    input wire logic tx_high_byte,
    output logic tx_ready,
    // Receive data
    input wire logic rd_low,
    input wire logic rd_high,
    output logic [7:0] rx_low_byte,
    output logic [7:0] rx_high_byte,
    output logic receive_complete_flag,
    // Pins
    input wire logic rx_line_in,
    output logic tx_line_out,
    output logic tx_line_oe,
    input wire logic transfer_clock_pin_in,
    output logic transfer_clock_pin_out,
    output logic transfer_clock_pin_oe
);
    typedef struct packed {
        logic rxd_m;
        logic rxd_s;
        logic xck_m;
        logic xck_s;
        logic [9:0] bcnt;
        logic [5:0] facc;
        logic [3:0] tsub;
        logic v;
        logic vp;
        logic xo;
        logic xoe;
        logic tx_on;
        logic dre;
        logic txd;
        logic hold_v;
        logic [8:0] hold_d;
        logic buf_v;
        logic [8:0] buf_d;
        logic sh_v;
        logic started;
        logic [usrx_pkg::FRAME_W-1:0] f;
        logic [3:0] sh_n;
        usrx_pkg::usrx_rx_st_t st;
        logic [3:0] sc;
        logic [2:0] vb;
        logic [3:0] nb;
        logic [8:0] rsh;
        logic rpar;
        logic parity_error_flag;
        logic push;
        logic [8:0] pd;
        logic pferr;
        logic pperr;
    } usrx_core_st_t;
    usrx_core_st_t s;
    usrx_core_st_t n;

    logic async, sync, spi, host, dbl, stick, cy, tx_tick, run;
    logic lead, trail, tx_lead, tev, sev, fin, fall, maj;
    logic bev, bval, spi_go, pop;
    logic [3:0] last, vote, nbits;
    logic [16:0] frm;

    // ==========================================
    // Helpers
    function automatic logic maj3(input logic [2:0] x);
        return (x[0] & x[1]) | (x[0] & x[2]) | (x[1] & x[2]);
    endfunction : maj3

    function automatic logic [7:0] rev8(input logic [7:0] x);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < 8; i++)
            r[i] = x[7-i];
        return r;
    endfunction : rev8

    // Frame as {length, bits}, first bit in bit 0, idle-high padding
    function automatic logic [16:0] mk_frame(input logic [8:0] d,
        input logic [3:0] nb, input logic [1:0] pm, input logic two);
        logic [12:0] f;
        logic p;
        logic [3:0] len;
        f = '1;
        p = pm[0];
        f[0] = 1'b0;
        for (int i = 0; i < 9; i++)
        begin
            if (i < int'(nb))
            begin
                f[i+1] = d[i];
                p = p ^ d[i];
            end
        end
        if (pm[1])
            f[nb+4'h1] = p;
        len = 4'h2 + nb + {3'h0, pm[1]} + {3'h0, two};
        return {len, f};
    endfunction : mk_frame

    // ==========================================
    // Mode decode
    always_comb
    begin
        async = (comm_mode == usrx_pkg::MODE_ASYNC);
        sync = (comm_mode == usrx_pkg::MODE_SYNC);
        spi = (comm_mode == usrx_pkg::MODE_SPI);
        host = spi | (sync & transfer_clock_dir);
        dbl = (rx_mode == usrx_pkg::RXM_DOUBLE);
        last = dbl ? usrx_pkg::SMP_DBL : usrx_pkg::SMP_NORM;
        vote = dbl ? usrx_pkg::VOTE_DBL : usrx_pkg::VOTE_NORM;
        if (spi)
            nbits = usrx_pkg::SPI_BITS;
        else if (character_size[2])
            nbits = usrx_pkg::MAX_BITS;
        else
            nbits = 4'h5 + {1'b0, character_size};
        pop = (character_size == usrx_pkg::CHS_9L && !spi) ? rd_high
            : rd_low;
    end

    // ==========================================
    // Next state
    always_comb
    begin
        n = s;
        n.rxd_m = rx_line_in;
        n.rxd_s = s.rxd_m;
        n.xck_m = transfer_clock_pin_in;
        n.xck_s = s.xck_m;
        n.push = 1'b0;
        cy = 1'b0;
        spi_go = 1'b0;
        frm = '0;
        // Baud generator; fraction used only for async rates
        stick = (s.bcnt == 10'h0);
        if (stick)
        begin
            {cy, n.facc} = {1'b0, s.facc}
                + (async ? {1'b0, baud_div[5:0]} : 7'h0);
            n.bcnt = baud_div[15:6] - 10'h1 + {9'h0, cy};
        end
        else
            n.bcnt = s.bcnt - 10'h1;
        tx_tick = stick && s.tsub == last;
        if (stick)
            n.tsub = tx_tick ? 4'h0 : s.tsub + 4'h1;
        // Transfer clock, normalised so a rise is the leading edge
        run = spi ? s.sh_v : sync;
        if (!host)
            n.v = s.xck_s ^ pin_invert_enable;
        else if (stick && run)
            n.v = !s.v;
        else if (!run)
            n.v = 1'b0;
        n.vp = s.v;
        n.xo = n.v ^ pin_invert_enable;
        n.xoe = host;
        lead = s.v & !s.vp;
        trail = !s.v & s.vp;
        tx_lead = !(spi && !clock_phase_select);
        tev = async ? tx_tick : (tx_lead ? lead : trail);
        sev = tx_lead ? trail : lead;
        // ======================================
        // Transmit path
        n.tx_on = tx_enable
            | (s.tx_on & (s.hold_v | s.buf_v | s.sh_v));
        if (!s.buf_v && s.hold_v)
        begin
            n.buf_v = 1'b1;
            n.buf_d = s.hold_d;
            n.hold_v = 1'b0;
        end
        if (tx_write && tx_enable && !s.hold_v)
        begin
            n.hold_v = 1'b1;
            n.hold_d = {tx_high_byte, tx_low_byte};
        end
        fin = s.started && s.sh_n == 4'h1 && (spi ? trail : tev);
        if (!s.sh_v && s.buf_v && s.tx_on)
        begin
            if (spi)
                frm = {usrx_pkg::SPI_BITS, 5'h1f, bit_order_select
                    ? rev8(s.buf_d[7:0]) : s.buf_d[7:0]};
            else
                frm = mk_frame(s.buf_d, nbits, parity_mode, two_stop);
            n.f = frm[12:0];
            n.sh_n = frm[16:13];
            n.sh_v = 1'b1;
            n.buf_v = 1'b0;
            n.started = spi && !clock_phase_select;
            spi_go = spi;
        end
        else if (s.sh_v && fin)
        begin
            n.sh_v = 1'b0;
            n.started = 1'b0;
        end
        else if (s.sh_v && tev)
        begin
            if (!s.started)
                n.started = 1'b1;
            else
            begin
                n.f = {1'b1, s.f[usrx_pkg::FRAME_W-1:1]};
                n.sh_n = s.sh_n - 4'h1;
            end
        end
        n.txd = n.started ? n.f[0] : usrx_pkg::LINE_IDLE;
        n.dre = !n.hold_v;
        // ======================================
        // Receive sampling
        if (stick)
            n.vb = {s.vb[1:0], s.rxd_s};
        fall = stick && s.vb[0] && !s.rxd_s;
        maj = maj3({s.vb[1:0], s.rxd_s});
        if (async)
        begin
            // Count lags the first low sample by one: vote on centre
            bev = stick && s.st != usrx_pkg::RX_IDLE
                && s.sc == vote + 4'h1;
            bval = maj;
        end
        else
        begin
            bev = sev && s.st != usrx_pkg::RX_IDLE;
            bval = s.rxd_s;
        end
        if (stick && async)
        begin
            if (s.sc == last || (rx_mode == usrx_pkg::RXM_RESYNC && fall))
                n.sc = 4'h0;
            else
                n.sc = s.sc + 4'h1;
        end
        // ======================================
        // Receive frame assembly
        if (!rx_enable)
            n.st = usrx_pkg::RX_IDLE;
        else if (spi_go)
        begin
            n.st = usrx_pkg::RX_DATA;
            n.nb = 4'h0;
        end
        else
        begin
            case (s.st)
                usrx_pkg::RX_IDLE:
                begin
                    if (async ? fall : (sev && !s.rxd_s && !spi))
                    begin
                        n.st = async ? usrx_pkg::RX_START
                            : usrx_pkg::RX_DATA;
                        n.sc = 4'h0;
                        n.nb = 4'h0;
                        n.rpar = 1'b0;
                    end
                end
                usrx_pkg::RX_START:
                begin
                    if (bev)
                        n.st = bval ? usrx_pkg::RX_IDLE
                            : usrx_pkg::RX_DATA;
                end
                usrx_pkg::RX_DATA:
                begin
                    if (bev)
                    begin
                        n.rsh = {bval, s.rsh[8:1]};
                        n.rpar = s.rpar ^ bval;
                        n.nb = s.nb + 4'h1;
                        n.parity_error_flag = 1'b0;
                        if (n.nb == nbits && spi)
                        begin
                            n.st = usrx_pkg::RX_IDLE;
                            n.push = 1'b1;
                            n.pd = {1'b0, bit_order_select
                                ? rev8(n.rsh[8:1]) : n.rsh[8:1]};
                            n.pferr = 1'b0;
                            n.pperr = 1'b0;
                        end
                        else if (n.nb == nbits)
                            n.st = parity_mode[1] ? usrx_pkg::RX_PAR
                                : usrx_pkg::RX_STOP;
                    end
                end
                usrx_pkg::RX_PAR:
                begin
                    if (bev)
                    begin
                        n.parity_error_flag = bval ^ s.rpar ^ parity_mode[0];
                        n.st = usrx_pkg::RX_STOP;
                    end
                end
                usrx_pkg::RX_STOP:
                begin
                    if (bev)
                    begin
                        n.st = usrx_pkg::RX_IDLE;
                        n.push = 1'b1;
                        n.pd = 9'(s.rsh >> (usrx_pkg::MAX_BITS - nbits));
                        n.pferr = !bval;
                        n.pperr = s.parity_error_flag;
                    end
                end
                default:
                    n.st = usrx_pkg::RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s <= '0;
            s.rxd_m <= usrx_pkg::LINE_IDLE;
            s.rxd_s <= usrx_pkg::LINE_IDLE;
            s.txd <= usrx_pkg::LINE_IDLE;
            s.dre <= 1'b1;
            s.vb <= usrx_pkg::VOTE_IDLE;
        end
        else
            s <= n;
    end

    // ==========================================
    // Receive buffer
    usrx_rxbuf #(
        .DEPTH(usrx_pkg::RXBUF_DEPTH)
    ) u_rxbuf (
        .clk(clk),
        .rst_b(rst_b),
        .flush(!rx_enable),
        .push(s.push),
        .push_data(s.pd),
        .push_frame_error_flag(s.pferr),
        .push_parity_error_flag(s.pperr),
        .ovf_en(!spi),
        .pop(pop),
        .low_byte(rx_low_byte),
        .high_byte(rx_high_byte),
        .not_empty(receive_complete_flag)
    );

    // Pin released to port control while the transmitter is off
    assign tx_line_oe = s.tx_on;
    assign tx_line_out = s.txd;
    assign tx_ready = s.dre;
    assign transfer_clock_pin_out = s.xo;
    assign transfer_clock_pin_oe = s.xoe;

    // ==========================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_tx_defer: assert property (
        s.tx_on && !tx_enable && (s.hold_v | s.buf_v | s.sh_v)
        |=> s.tx_on)
        else $error("Transmitter stopped with data pending");
    a_pin_release: assert property (
        !tx_line_oe |-> !s.sh_v && tx_line_out)
        else $error("Released pin still carries a frame");
    a_rx_kill: assert property (
        !rx_enable |=> s.st == usrx_pkg::RX_IDLE ##1 !receive_complete_flag)
        else $error("Receiver disable did not flush");
    a_rxc_set: assert property (
        s.push && rx_enable |=> receive_complete_flag)
        else $error("Receive flag not set after frame");
    a_spi_clean: assert property (
        s.push && $past(spi) |-> !s.pferr && !s.pperr)
        else $error("SPI frame carries an error flag");
    a_stop_frame_error_flag: assert property (
        s.st == usrx_pkg::RX_STOP && bev && !bval && rx_enable
        |=> s.push && s.pferr)
        else $error("Low stop bit without frame error");
    a_host_clk: assert property (
        spi |=> transfer_clock_pin_oe)
        else $error("SPI host not driving the clock");
    c_async_frame: cover property (async && s.push);
    c_spi_frame: cover property (spi && s.push);
    c_tx_off: cover property ($fell(s.tx_on));
endmodule : usrx_core
`default_nettype wire

// ==== testbench/usrx_remote.sv ====
// Remote node model: async frame sender and SPI client
`default_nettype none
module usrx_remote (
    // Serial link
    input wire logic sck,
    input wire logic mosi,
    output logic rxd
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] spi_out;
    logic [7:0] spi_in;
    logic spi_on;
    int edges;
    initial
    begin
        rxd = 1'b1;
        spi_on = 1'b0;
        spi_in = 8'h00;
        spi_out = 8'h00;
        edges = 0;
    end
    // ==========================================
    // Async sender: low start, bits LSb first, line idles high
    task automatic send(input logic [11:0] bits, input int n,
        input int bit_ns);
        rxd = 1'b0;
        #(bit_ns);
        for (int i = 0; i < n; i++)
        begin
            rxd = bits[i];
            #(bit_ns);
        end
        rxd = 1'b1;
    endtask : send
    // ==========================================
    // SPI client, MSb first; pre puts the first bit out before any edge
    task automatic spi_load(input logic [7:0] b, input logic pre);
        spi_out = pre ? {b[6:0], 1'b0} : b;
        if (pre)
            rxd = b[7];
        edges = 0;
        spi_on = 1'b1;
    endtask : spi_load
    always @(sck)
    begin
        if (spi_on && sck)
        begin
            spi_in = {spi_in[6:0], mosi};
            edges++;
        end
        else if (spi_on)
        begin
            rxd = spi_out[7];
            spi_out = {spi_out[6:0], 1'b0};
        end
    end
endmodule : usrx_remote
`default_nettype wire

// ==== testbench/usrx_core_test.sv ====
// Self-checking bench of the serial receive core
`default_nettype none
module usrx_core_test;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Stimulus and observed signals
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [1:0] comm_mode = 2'h0;
    logic [1:0] rx_mode = 2'h0;
    logic [2:0] chs = 3'h3;
    logic [1:0] par = 2'h2;
    logic order = 1'b0;
    logic dir = 1'b0;
    logic cpha = 1'b0;
    logic inv = 1'b0;
    logic transfer_clock_pin = 1'b0;
    logic [15:0] baud = 16'h0080;
    logic tx_en = 1'b1;
    logic rx_en = 1'b1;
    logic tx_wr = 1'b0;
    logic [7:0] tx_lo = 8'h00;
    logic tx_hi = 1'b0;
    logic rd_low = 1'b0;
    logic rd_high = 1'b0;
    logic tx_ready, rx_flag, tx_out, tx_oe, sck, sck_oe, rxd;
    logic [7:0] rx_lo, rx_hi;
    int errors = 0;
    int compares = 0;
    int bit_ns = 640;
    always #10 clk = ~clk;
    usrx_core i_dut (
        .clk(clk), .rst_b(rst_b), .comm_mode(comm_mode),
        .rx_mode(rx_mode), .character_size(chs), .parity_mode(par),
        .two_stop(1'b0), .bit_order_select(order),
        .clock_phase_select(cpha), .pin_invert_enable(inv),
        .transfer_clock_dir(dir), .baud_div(baud), .tx_enable(tx_en),
        .rx_enable(rx_en), .tx_write(tx_wr), .tx_low_byte(tx_lo),
        .tx_high_byte(tx_hi), .tx_ready(tx_ready), .rd_low(rd_low),
        .rd_high(rd_high), .rx_low_byte(rx_lo), .rx_high_byte(rx_hi),
        .receive_complete_flag(rx_flag), .rx_line_in(rxd),
        .tx_line_out(tx_out), .tx_line_oe(tx_oe),
        .transfer_clock_pin_in(transfer_clock_pin), .transfer_clock_pin_out(sck),
        .transfer_clock_pin_oe(sck_oe)
    );
    usrx_remote i_remote (
        .sck(sck),
        .mosi(tx_out),
        .rxd(rxd)
    );
    // ==========================================
    // Shared helpers; inputs move 2 ns after the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : tick
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic frame(input logic [11:0] bits);
        i_remote.send(bits, 10, bit_ns);
        tick(4);
    endtask : frame
    task automatic read(input logic hi);
        rd_high = hi;
        rd_low = !hi;
        tick(1);
        rd_high = 1'b0;
        rd_low = 1'b0;
        tick(3);
    endtask : read
    task automatic head(input logic [7:0] lo, input logic [7:0] hi);
        check(rx_lo, lo);
        check(rx_hi, hi);
    endtask : head
    task automatic strobe();
        tx_wr = 1'b1;
        tick(1);
        tx_wr = 1'b0;
        tick(2);
    endtask : strobe
    // ==========================================
    // Scenarios
    task automatic t_basic();
        frame({1'b1, 1'b0, 8'h4b});
        check(rx_flag, 1'b1);
        head(8'h4b, 8'h80);
        read(1'b1);
        head(8'h4b, 8'h80);
        read(1'b0);
        check(rx_flag, 1'b0);
    endtask : t_basic
    task automatic t_overflow();
        frame({1'b1, 1'b0, 8'h11});
        frame({1'b1, 1'b0, 8'h22});
        frame({1'b1, 1'b0, 8'h33});
        head(8'h11, 8'h80);
        read(1'b1);
        read(1'b0);
        head(8'h33, 8'hc0);
        read(1'b1);
        read(1'b0);
        check(rx_flag, 1'b0);
    endtask : t_overflow
    task automatic t_errors();
        par = 2'h3;
        frame({1'b0, 1'b1, 8'h01});
        head(8'h01, 8'h86);
        read(1'b0);
        par = 2'h0;
        chs = usrx_pkg::CHS_9L;
        frame({2'b11, 9'h1a5});
        read(1'b0);
        head(8'ha5, 8'h81);
        read(1'b1);
        check(rx_flag, 1'b0);
        chs = 3'h3;
        par = 2'h2;
    endtask : t_errors
    task automatic t_double();
        rx_mode = usrx_pkg::RXM_DOUBLE;
        bit_ns = 320;
        frame({1'b1, 1'b0, 8'h5a});
        head(8'h5a, 8'h80);
        // Drop the enable mid-frame: buffer and shifter both go
        fork
            i_remote.send({1'b1, 1'b0, 8'hff}, 10, bit_ns);
            begin
                #(3 * bit_ns);
                rx_en = 1'b0;
            end
        join
        tick(3);
        head(8'h00, 8'h00);
        rx_en = 1'b1;
        rx_mode = 2'h0;
        bit_ns = 640;
    endtask : t_double
    task automatic t_txoff();
        par = 2'h0;
        strobe();
        strobe();
        strobe();
        check(tx_ready, 1'b0);
        tx_en = 1'b0;
        #(15 * bit_ns);
        check(tx_oe, 1'b1);
        #(20 * bit_ns);
        check(tx_oe, 1'b0);
        tx_en = 1'b1;
        par = 2'h2;
    endtask : t_txoff
    task automatic t_client();
        comm_mode = usrx_pkg::MODE_SYNC;
        tick(4);
        fork
            i_remote.send({1'b1, 1'b1, 8'h61}, 10, 320);
            // Client clock well below a quarter of the core clock
            repeat (11)
            begin
                transfer_clock_pin = 1'b1;
                #160;
                transfer_clock_pin = 1'b0;
                #160;
            end
        join
        tick(4);
        head(8'h61, 8'h80);
        read(1'b0);
        check(rx_flag, 1'b0);
    endtask : t_client
    task automatic t_spi();
        comm_mode = 2'h1;
        tick(4);
        check(sck_oe, 1'b0);
        dir = 1'b1;
        tick(4);
        check(sck_oe, 1'b1);
        dir = 1'b0;
        comm_mode = usrx_pkg::MODE_SPI;
        order = 1'b1;
        baud = 16'h0200;
        tick(2);
        i_remote.spi_load(8'h4e, 1'b1);
        tx_lo = 8'hc1;
        strobe();
        for (int i = 0; i < 600 && rx_flag !== 1'b1; i++)
            tick(1);
        check(i_remote.spi_in, 8'hc1);
        check(16'(i_remote.edges), 16'h0008);
        head(8'h4e, 8'h80);
        i_remote.spi_on = 1'b0;
        i_remote.rxd = 1'b1;
        read(1'b0);
        check(rx_flag, 1'b0);
        // Other phase and polarity, LSb first
        cpha = 1'b1;
        inv = 1'b1;
        order = 1'b0;
        tick(2);
        i_remote.spi_load(8'hc8, 1'b0);
        tx_lo = 8'h2d;
        strobe();
        for (int i = 0; i < 600 && rx_flag !== 1'b1; i++)
            tick(1);
        check(i_remote.spi_in, 8'hb4);
        check(16'(i_remote.edges), 16'h0008);
        head(8'h13, 8'h80);
        i_remote.spi_on = 1'b0;
        read(1'b0);
        check(rx_flag, 1'b0);
    endtask : t_spi
    // ==========================================
    // Verdict, main sequence and watchdog
    task automatic report_and_stop();
        if (errors == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop
    initial
    begin
        tick(3);
        rst_b = 1'b1;
        tick(2);
        for (int m = 0; m < 4; m++)
        begin
            rx_mode = 2'(m);
            if (m != 1)
                t_basic();
        end
        rx_mode = 2'h0;
        t_overflow();
        t_errors();
        t_double();
        t_txoff();
        t_client();
        t_spi();
        report_and_stop();
    end
    initial
    begin
        #300000;
        errors++;
        report_and_stop();
    end
endmodule : usrx_core_test
`default_nettype wire
